// ===== pkg/vdp_pkg.sv
// Constants and types shared by the variable duty pulse output block.
// Assumes a single 200 MHz device clock and an active-high asynchronous reset.
//
// How it works
// - Duty accepted from 0.0 to 100.0 percent in 0.1 percent steps.
// - Fine range gives 0.1 Hz to 6553.5 Hz in 0.1 Hz steps.
// - Coarse range gives 1 Hz to 32800 Hz in 1 Hz steps.
// - Output runs continuously once started until stopped explicitly.
// - Home search in mode 1 or 2 on a duty-used channel flags a command error.
// - Status flags refresh on stop commands, limit stops, reset flag and operating state changes.
// - Limit stop with origin held keeps present value, clears busy flags, may set stop error.
// - Limit stop with undefined origin zeroes value and overflow, clears busy, sets no-origin.
// - Duty in-progress flag reads one while emitting, zero while stopped.
// - Initialise/stop command halts a running duty output.
// - New duty ratio applied while running without stopping the train.
package vdp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ         = 64'd200000000;
  localparam int     NUM_CH         = 4;
  localparam int     DUTY_FULL      = 1000;           // 100.0 percent in 0.1 percent steps
  localparam logic [15:0] DUTY_MAX  = 16'h03e8;
  localparam logic [15:0] COARSE_MAX = 16'h8020;      // 32800 Hz
  // Cycles per period numerator: fine range counts in 0.1 Hz, coarse in 1 Hz
  localparam longint FINE_NUM       = CLK_HZ * 64'd10;
  localparam longint COARSE_NUM     = CLK_HZ;
  localparam int     PER_W          = 32;              // 2e9 cycles max fits 32 bits

  // Reset values
  localparam logic [31:0] PV_RESET  = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VDP_CMD_NONE  = 2'h0,
    VDP_CMD_START = 2'h1,   // Start or change duty/frequency
    VDP_CMD_STOP  = 2'h2    // initialise_stop_command
  } vdp_cmd_e;

  // Command from the processor for one channel
  typedef struct packed {
    vdp_cmd_e    cmd;
    logic [1:0]  chan;
    logic        coarse;     // 1: whole-hertz steps
    logic [15:0] freq;
    logic [15:0] duty;
  } vdp_cmd_s;

  // Per-channel pulse status flags
  typedef struct packed {
    logic accel;
    logic overflow;
    logic out_busy;
    logic no_origin;
    logic stop_err;
    logic feed_busy;
  } vdp_flags_s;

endpackage

// ===== hw/vdp_channel.sv
// One variable duty channel: period counter and high-time compare.
// Assumes period and high counts are computed by the parent on the same clock.
`timescale 1ns/1ps
module vdp_channel #(
  parameter int PER_W = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [PER_W-1:0] period,
  input  wire logic [PER_W-1:0] high,
  output logic                  pulse
);
  import vdp_pkg::*;

  logic [PER_W-1:0] cnt_reg;
  logic [PER_W-1:0] per_reg;
  logic [PER_W-1:0] high_reg;

  // Period counter; wraps forever while running, no pulse count limit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (!run || load && !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg + 1'b1 >= per_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // New settings take effect immediately; counter keeps running
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      per_reg  <= '0;
      high_reg <= '0;
    end else if (load) begin
      per_reg  <= period;
      high_reg <= high;
    end
  end

  // Output high for the first high_reg cycles of each period
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse <= 1'b0;
    end else begin
      pulse <= run && (cnt_reg < high_reg);
    end
  end
endmodule

// ===== hw/vdp_top.sv
// Variable duty pulse output for four channels with pulse status bookkeeping.
// Assumes commands and events arrive as one-cycle pulses from logic on ref_clk.
`timescale 1ns/1ps
module vdp_top (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire vdp_pkg::vdp_cmd_s          cmd_in,
  input  wire logic                       home_search_command,
  input  wire logic [1:0]                 home_chan,
  input  wire logic [1:0]                 home_mode,
  input  wire logic                       reset_flag,
  input  wire logic                       op_state_change,
  input  wire logic                       limit_stop,
  input  wire logic [1:0]                 limit_chan,
  input  wire logic                       origin_held,
  input  wire logic                       stop_err_update,
  output logic [3:0]                      duty_terminal,
  output logic [3:0]                      duty_busy,
  output logic                            cmd_error,
  output logic [31:0]                     present_value [4],
  output vdp_pkg::vdp_flags_s             pulse_flags [4]
);
  import vdp_pkg::*;

  // ****************************************************************
  // Command decode and period math
  // ****************************************************************
  logic [PER_W-1:0] per_calc;
  logic [PER_W-1:0] high_calc;
  logic [47:0]      prod;
  logic             cmd_ok;
  logic [NUM_CH-1:0] load;

  // Operands are unsigned step counts; zero frequency or out of range refused
  always_comb begin
    cmd_ok = (cmd_in.cmd == VDP_CMD_START) && (cmd_in.freq != 16'h0000) && (cmd_in.duty <= DUTY_MAX)
             && (!cmd_in.coarse || cmd_in.freq <= COARSE_MAX);
    if (cmd_in.freq == 16'h0000) begin
      per_calc = '0;
    end else if (cmd_in.coarse) begin
      per_calc = PER_W'(COARSE_NUM / {48'h0, cmd_in.freq});
    end else begin
      per_calc = PER_W'(FINE_NUM / {48'h0, cmd_in.freq});
    end
    // Rounded high time: (period*duty + 500)/1000
    prod      = 48'(per_calc) * 48'(cmd_in.duty) + 48'(DUTY_FULL / 2);
    high_calc = PER_W'(prod / 48'(DUTY_FULL));
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  logic [NUM_CH-1:0] run_reg;
  logic [NUM_CH-1:0] pulse_w;
  logic [NUM_CH-1:0] stop_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign load[g]     = cmd_ok && (cmd_in.chan == 2'(g));
      assign stop_hit[g] = (cmd_in.cmd == VDP_CMD_STOP) && (cmd_in.chan == 2'(g));

      vdp_channel #(.PER_W(PER_W)) u_ch (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (run_reg[g]),
        .load    (load[g]),
        .period  (per_calc),
        .high    (high_calc),
        .pulse   (pulse_w[g])
      );

      // Run state: start on load, stop on stop command or operating change
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          run_reg[g] <= 1'b0;
        end else if (stop_hit[g] || op_state_change) begin
          run_reg[g] <= 1'b0;
        end else if (load[g]) begin
          run_reg[g] <= 1'b1;
        end
      end

      // Pulse status bookkeeping per channel
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          present_value[g] <= PV_RESET;
          pulse_flags[g]   <= '{default: 1'b0, no_origin: 1'b1};   // Power-up state
        end else if (limit_stop && limit_chan == 2'(g)) begin
          pulse_flags[g].accel     <= 1'b0;
          pulse_flags[g].out_busy  <= 1'b0;
          pulse_flags[g].feed_busy <= 1'b0;
          if (origin_held) begin
            // Present value kept; stop error updated only on request
            if (stop_err_update) begin
              pulse_flags[g].stop_err <= 1'b1;
            end
          end else begin
            present_value[g]         <= PV_RESET;
            pulse_flags[g].overflow  <= 1'b0;
            pulse_flags[g].no_origin <= 1'b1;
          end
        end else if (stop_hit[g]) begin
          // Initialise/stop clears busy and overflow flags
          pulse_flags[g].accel     <= 1'b0;
          pulse_flags[g].overflow  <= 1'b0;
          pulse_flags[g].out_busy  <= 1'b0;
          pulse_flags[g].no_origin <= 1'b0;
          pulse_flags[g].feed_busy <= 1'b0;
        end else if (op_state_change) begin
          pulse_flags[g].accel     <= 1'b0;
          pulse_flags[g].out_busy  <= 1'b0;
          pulse_flags[g].feed_busy <= 1'b0;
        end else if (reset_flag) begin
          pulse_flags[g].overflow  <= 1'b0;
          pulse_flags[g].no_origin <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Registered terminal drive and in-progress flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      duty_terminal <= '0;
      duty_busy     <= '0;
    end else begin
      duty_terminal <= pulse_w;
      duty_busy     <= run_reg;
    end
  end

  // Home search in mode 1/2 needs the terminal a running duty channel owns
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= home_search_command && (home_mode == 2'h1 || home_mode == 2'h2) && run_reg[home_chan];
    end
  end
endmodule

// ===== sim/vdp_checker.sv
// Pin-level assertions for the variable duty pulse block.
// Bound to vdp_top from the bench top file; one clock, async reset.
`timescale 1ns/1ps
module vdp_checker (
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire vdp_pkg::vdp_cmd_s   cmd_in,
  input wire logic                home_search_command,
  input wire logic [1:0]          home_chan,
  input wire logic [1:0]          home_mode,
  input wire logic                op_state_change,
  input wire logic                limit_stop,
  input wire logic [1:0]          limit_chan,
  input wire logic                origin_held,
  input wire logic [3:0]          duty_terminal,
  input wire logic [3:0]          duty_busy,
  input wire logic                cmd_error,
  input wire logic [31:0]         present_value [4],
  input wire vdp_pkg::vdp_flags_s pulse_flags [4]
);
  import vdp_pkg::*;
  logic [1:0] lc_q;
  // Remember which channel hit its limit, flags answer one edge later
  always_ff @(posedge ref_clk) begin
    lc_q <= limit_chan;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ********
  // Properties
  // ********
  chk_busy_cause: assert property ($rose(duty_busy[0]) |-> $past(cmd_in.cmd, 2) == VDP_CMD_START)
    else $error("busy rose without a start");
  chk_stop_clear: assert property (cmd_in.cmd == VDP_CMD_STOP |-> ##2 !duty_busy[$past(cmd_in.chan, 2)])
    else $error("stop left channel busy");
  chk_op_clear: assert property (op_state_change |-> ##2 duty_busy == 4'h0)
    else $error("state change left a channel busy");
  chk_err_flag: assert property (home_search_command && home_mode inside {2'h1, 2'h2}
    && duty_busy[home_chan] |=> cmd_error)
    else $error("home search on duty channel not refused");
  chk_err_cause: assert property (cmd_error |-> $past(home_search_command) && $past(home_mode) inside {2'h1, 2'h2})
    else $error("error without a home search");
  // Terminal must be quiet once busy has been low for two samples
  chk_idle_low: assert property (!duty_busy[0] && !$past(duty_busy[0]) |-> !duty_terminal[0])
    else $error("terminal active while stopped");
  chk_lim_busy: assert property (limit_stop |=> pulse_flags[lc_q].out_busy == 1'b0
    && pulse_flags[lc_q].accel == 1'b0 && pulse_flags[lc_q].feed_busy == 1'b0)
    else $error("limit stop left busy flags");
  chk_lim_undef: assert property (limit_stop && !origin_held |=> present_value[lc_q] == 32'h0
    && pulse_flags[lc_q].no_origin && !pulse_flags[lc_q].overflow)
    else $error("undefined origin stop not cleared");
  cov_err: cover property (cmd_error);
  cov_run: cover property ($rose(duty_busy[0]));
  cov_lim: cover property (limit_stop && !origin_held);
endmodule

// ===== sim/vdp_load.sv
// External load on one duty terminal: measures high time and period.
// Sees the terminal on ref_clk; first figures after start are partial.
`timescale 1ns/1ps
module vdp_load (
  input wire logic ref_clk,
  input wire logic drive,
  output int       hi_len,
  output int       per_len
);
  logic prev_q = 1'b0;
  int   hc     = 0;
  int   pc     = 0;
  // Latch counts on each rising edge of the load current
  always @(posedge ref_clk) begin
    if (drive && !prev_q) begin
      hi_len <= hc;
      per_len <= pc;
      hc = 1;
      pc = 1;
    end else begin
      hc = hc + int'(drive);
      pc = pc + 1;
    end
    prev_q <= drive;
  end
endmodule

// ===== sim/vdp_top_tb.sv
// Self-checking bench for vdp_top with four measuring loads.
// Inputs change 1 ns after the rising edge; one 200 MHz clock.
`timescale 1ns/1ps
module vdp_top_tb;
  import vdp_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, cmd_error;
  vdp_cmd_s    cmd_in = '0;
  logic        home_search_command = 1'b0, reset_flag = 1'b0, op_state_change = 1'b0;
  logic        limit_stop = 1'b0, origin_held = 1'b0, stop_err_update = 1'b0;
  logic [1:0]  home_chan = 2'h0, home_mode = 2'h0, limit_chan = 2'h0;
  logic [3:0]  duty_terminal, duty_busy;
  logic [31:0] present_value [4];
  vdp_flags_s  pulse_flags [4];
  int          hi [4], per [4];
  int          miscompares = 0, total_checks = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  vdp_top u_vdp_top (.ref_clk, .reset, .cmd_in, .home_search_command, .home_chan, .home_mode, .reset_flag,
    .op_state_change, .limit_stop, .limit_chan, .origin_held, .stop_err_update, .duty_terminal,
    .duty_busy, .cmd_error, .present_value, .pulse_flags);
  for (genvar i = 0; i < 4; i++) begin : g_ld
    vdp_load u_vdp_load (.ref_clk, .drive(duty_terminal[i]), .hi_len(hi[i]), .per_len(per[i]));
  end
  // Hang guard, well above the roughly 53k cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic start(logic [1:0] ch, logic co, logic [15:0] f, logic [15:0] d);
    cmd_in = '{VDP_CMD_START, ch, co, f, d};
    tick();
    cmd_in.cmd = VDP_CMD_NONE;
    tick(2);
  endtask
  task automatic home(logic [1:0] ch, logic [1:0] m, logic exp);
    home_search_command = 1'b1;
    home_chan = ch;
    home_mode = m;
    tick();
    home_search_command = 1'b0;
    chk(cmd_error, exp);
    tick();
  endtask
  task automatic lim(logic [1:0] ch, logic held, logic [5:0] mask, logic [5:0] exp);
    limit_stop = 1'b1;
    limit_chan = ch;
    origin_held = held;
    stop_err_update = held;
    tick();
    limit_stop = 1'b0;
    chk(pulse_flags[ch] & mask, exp);
    chk(present_value[ch], 32'h0);
    tick();
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence: refusals, four channels, duty change, stops
  initial begin
    tick(8);
    reset = 1'b0;
    chk(pulse_flags[0], 6'h04);
    start(2'h3, 1'b0, 16'h0000, 16'h0190);
    start(2'h3, 1'b1, 16'h8021, 16'h0190);
    start(2'h3, 1'b0, 16'h4e20, 16'h03e9);
    chk(duty_busy, 4'h0);
    for (int m = 0; m < 4; m++) home(2'h3, m[1:0], 1'b0);
    start(2'h0, 1'b1, 16'h4e20, 16'h0190);
    start(2'h1, 1'b0, 16'hffff, 16'h01f4);
    start(2'h2, 1'b1, 16'h8020, 16'h03e8);
    start(2'h3, 1'b1, 16'h4e20, 16'h0000);
    chk(duty_busy, 4'hf);
    for (int m = 0; m < 4; m++) home(2'h0, m[1:0], m == 1 || m == 2);
    tick(32000);
    chk(per[0], 200000000 / 20000);
    chk(hi[0], (10000 * 400 + 500) / 1000);
    chk(per[1], 2000000000 / 65535);
    chk(hi[1], (30518 * 500 + 500) / 1000);
    chk(duty_terminal[3:2], 2'h1);
    start(2'h0, 1'b1, 16'h4e20, 16'h00fa);
    chk(duty_busy[0], 1'b1);
    tick(21000);
    chk(hi[0], (10000 * 250 + 500) / 1000);
    lim(2'h2, 1'b0, 6'h3d, 6'h04);
    lim(2'h3, 1'b1, 6'h2b, 6'h02);
    cmd_in.cmd = VDP_CMD_STOP;
    tick();
    cmd_in.cmd = VDP_CMD_NONE;
    tick(3);
    chk({duty_busy[0], duty_terminal[0]}, 2'h0);
    reset_flag = 1'b1;
    tick();
    reset_flag = 1'b0;
    chk(pulse_flags[0] & 6'h14, 6'h04);
    op_state_change = 1'b1;
    tick();
    op_state_change = 1'b0;
    tick(2);
    chk({duty_busy, duty_terminal}, 8'h00);
    chk(pulse_flags[1] & 6'h29, 6'h00);
    wrap_up();
  end
endmodule
bind vdp_top vdp_checker u_vdp_checker (.ref_clk, .reset, .cmd_in, .home_search_command, .home_chan,
  .home_mode, .op_state_change, .limit_stop, .limit_chan, .origin_held, .duty_terminal, .duty_busy,
  .cmd_error, .present_value, .pulse_flags);
